// File: verilog/tpg_top.sv
// Timer/pulse generator: mode and modulo registers, pin and request flag.
// Assumes register accesses and flag clear are synchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Mode select bit 0 gives PWM mode, 1 gives interval timer mode.
// - Enable bit 0 halts the generator; it runs only while 1.
// - Timer mode starts timing on enable rising from 0 to 1.
// - Reload bit 1 copies modulo registers to latch; 0 holds latch.
// - Static data bit sets the latched level shown on static output.
// - Output select 0 drives static latch; 1 drives generated waveform.
// - Pin enable 0 floats the pulse pin; 1 drives it.
// - Reset clears the whole mode register to zero.
// - Timer interval is prescale 256..16 times N+1 clocks.
// - Timer raises request flag each interval and makes a matching square wave.
// - PWM mode raises the request flag every 2^15 clocks.
// - PWM output is active low; low width set by 14-bit latch.
// - PWM mixes a 2^10 basic period with a 2^15 secondary period.
// - Latch takes high modulo as top 8 bits, low modulo[7:2] below.
// - Low modulo bits 1:0 read back undefined; here they read zero.
// - Reload bit can be written alone without touching other bits.
module tpg_top
	import tpg_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire tpg_req_type reg_req,
	input wire logic reload_wr,
	input wire logic reload_wdata,
	input wire logic irq_clr,
	output logic [7:0] rdata,
	output logic pulse_output_pin,
	output logic pulse_output_pin_oe,
	output logic generator_irq_flag
);

	logic rst_meta_q;
	logic rst_q;
	tpg_mode_type mode_q;
	logic [7:0] modulo_high_q;
	logic [7:0] modulo_low_q;
	logic en_prev_q;
	logic tmr_run;
	logic pwm_run;
	logic tmr_start;
	logic tmr_tick;
	logic tmr_sq;
	logic pwm_tick;
	logic pwm_n;
	logic gen_tick;
	logic wave;

	// Reset release through two flops
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_meta_q <= 1'b0;
			rst_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_q <= rst_meta_q;
		end
	end

	// Mode register; the reload bit has its own write strobe
	always_ff @(posedge mclk or negedge rst_q)
	begin
		if (!rst_q)
			mode_q <= tpg_mode_type'(TPG_MODE_RST);
		else
		begin
			if (reg_req.wr && reg_req.addr == TPG_ADDR_MODE)
				mode_q <= tpg_mode_type'(reg_req.wdata & TPG_MODE_WMASK);
			if (reload_wr)
				mode_q.reload_en <= reload_wdata;
		end
	end

	always_ff @(posedge mclk or negedge rst_q)
	begin
		if (!rst_q)
		begin
			modulo_high_q <= TPG_MODULO_HIGH_RST;
			modulo_low_q <= TPG_MODULO_LOW_RST;
		end
		else if (reg_req.wr)
		begin
			if (reg_req.addr == TPG_ADDR_MODULO_HIGH)
				modulo_high_q <= reg_req.wdata;
			if (reg_req.addr == TPG_ADDR_MODULO_LOW)
				modulo_low_q <= reg_req.wdata;
		end
	end

	// Read port; unmapped addresses return zero
	always_ff @(posedge mclk or negedge rst_q)
	begin
		if (!rst_q)
			rdata <= 8'h00;
		else if (reg_req.rd)
		begin
			case (reg_req.addr)
				TPG_ADDR_MODE: rdata <= mode_q;
				TPG_ADDR_MODULO_HIGH: rdata <= modulo_high_q;
				TPG_ADDR_MODULO_LOW: rdata <= modulo_low_q & TPG_MODULO_LOW_RMASK;
				default: rdata <= 8'h00;
			endcase
		end
	end

	// Enable edge detect for timer start
	always_ff @(posedge mclk or negedge rst_q)
	begin
		if (!rst_q)
			en_prev_q <= 1'b0;
		else
			en_prev_q <= mode_q.gen_en;
	end

	assign tmr_run = mode_q.gen_en && mode_q.mode_sel;
	assign pwm_run = mode_q.gen_en && !mode_q.mode_sel;
	assign tmr_start = tmr_run && !en_prev_q;

	tpg_interval u_interval (
		.mclk(mclk),
		.rst_n(rst_q),
		.run(tmr_run),
		.start(tmr_start),
		.modulo_low(modulo_low_q),
		.modulo_high(modulo_high_q),
		.tick(tmr_tick),
		.sq(tmr_sq)
	);

	tpg_pwm u_pwm (
		.mclk(mclk),
		.rst_n(rst_q),
		.run(pwm_run),
		.reload_en(mode_q.reload_en),
		.modulo_high(modulo_high_q),
		.modulo_low(modulo_low_q),
		.pwm_n(pwm_n),
		.tick(pwm_tick)
	);

	assign gen_tick = tmr_tick || pwm_tick;
	assign wave = mode_q.mode_sel ? tmr_sq : pwm_n;

	// Request flag: a tick in the clear cycle wins
	always_ff @(posedge mclk or negedge rst_q)
	begin
		if (!rst_q)
			generator_irq_flag <= 1'b0;
		else if (gen_tick)
			generator_irq_flag <= 1'b1;
		else if (irq_clr)
			generator_irq_flag <= 1'b0;
	end

	// Pulse pin and its enable
	always_ff @(posedge mclk or negedge rst_q)
	begin
		if (!rst_q)
		begin
			pulse_output_pin <= 1'b0;
			pulse_output_pin_oe <= 1'b0;
		end
		else
		begin
			pulse_output_pin <= mode_q.out_sel ? wave : mode_q.stat_data;
			pulse_output_pin_oe <= mode_q.pin_oe;
		end
	end

	a_reset_mode_zero: assert property (@(posedge mclk) disable iff (!rst_q)
		$rose(rst_q) |-> mode_q == tpg_mode_type'(TPG_MODE_RST) && !pulse_output_pin_oe)
		else $error("mode register not zero after reset");

	a_halt_no_tick: assert property (@(posedge mclk) disable iff (!rst_q)
		!mode_q.gen_en [*2] |=> !gen_tick)
		else $error("generator ticked while disabled");

	a_static_pin_level: assert property (@(posedge mclk) disable iff (!rst_q)
		!mode_q.out_sel |=> pulse_output_pin == $past(mode_q.stat_data))
		else $error("static level not on pulse pin");

	a_pulse_pin_wave: assert property (@(posedge mclk) disable iff (!rst_q)
		mode_q.out_sel |=> pulse_output_pin == $past(wave))
		else $error("generated waveform not on pulse pin");

	a_pin_enable_follow: assert property (@(posedge mclk) disable iff (!rst_q)
		$changed(mode_q.pin_oe) |=> pulse_output_pin_oe == $past(mode_q.pin_oe))
		else $error("pin enable did not follow mode bit");

	a_irq_set_wins: assert property (@(posedge mclk) disable iff (!rst_q)
		(gen_tick && irq_clr) |=> generator_irq_flag)
		else $error("request flag lost when set and clear met");

	a_reload_bit_alone: assert property (@(posedge mclk) disable iff (!rst_q)
		(reload_wr && !reg_req.wr) |=> mode_q.reload_en == $past(reload_wdata)
			&& {mode_q[7:4], mode_q[2:0]} == $past({mode_q[7:4], mode_q[2:0]}))
		else $error("reload bit write disturbed mode register");

	a_timer_mode_only: assert property (@(posedge mclk) disable iff (!rst_q)
		(!mode_q.mode_sel && !$past(mode_q.mode_sel)) |-> !tmr_tick)
		else $error("timer ticked in pwm mode");

	a_pwm_tick_mode: assert property (@(posedge mclk) disable iff (!rst_q)
		(mode_q.mode_sel && $past(mode_q.mode_sel)) |-> !pwm_tick)
		else $error("pwm ticked in timer mode");

	a_mode_write_mask: assert property (@(posedge mclk) disable iff (!rst_q)
		(reg_req.wr && reg_req.addr == TPG_ADDR_MODE && !reload_wr)
			|=> mode_q == ($past(reg_req.wdata) & TPG_MODE_WMASK))
		else $error("mode register write not taken");

	a_reload_over_write: assert property (@(posedge mclk) disable iff (!rst_q)
		(reg_req.wr && reg_req.addr == TPG_ADDR_MODE && reload_wr)
			|=> mode_q.reload_en == $past(reload_wdata))
		else $error("reload strobe lost against mode write");

	a_mode_hold: assert property (@(posedge mclk) disable iff (!rst_q)
		(!(reg_req.wr && reg_req.addr == TPG_ADDR_MODE) && !reload_wr) |=> $stable(mode_q))
		else $error("mode register changed without a write");

	a_modulo_high_write: assert property (@(posedge mclk) disable iff (!rst_q)
		(reg_req.wr && reg_req.addr == TPG_ADDR_MODULO_HIGH) |=> modulo_high_q == $past(reg_req.wdata))
		else $error("high modulo write not taken");

	a_modulo_low_write: assert property (@(posedge mclk) disable iff (!rst_q)
		(reg_req.wr && reg_req.addr == TPG_ADDR_MODULO_LOW) |=> modulo_low_q == $past(reg_req.wdata))
		else $error("low modulo write not taken");

	a_modulo_hold: assert property (@(posedge mclk) disable iff (!rst_q)
		!(reg_req.wr && (reg_req.addr == TPG_ADDR_MODULO_HIGH || reg_req.addr == TPG_ADDR_MODULO_LOW))
			|=> $stable(modulo_high_q) && $stable(modulo_low_q))
		else $error("modulo register changed without a write");

	a_modulo_low_read_mask: assert property (@(posedge mclk) disable iff (!rst_q)
		(reg_req.rd && reg_req.addr == TPG_ADDR_MODULO_LOW)
			|=> rdata == ($past(modulo_low_q) & TPG_MODULO_LOW_RMASK))
		else $error("low modulo read wrong");

	a_mode_read_back: assert property (@(posedge mclk) disable iff (!rst_q)
		(reg_req.rd && reg_req.addr == TPG_ADDR_MODE) |=> rdata == $past(mode_q))
		else $error("mode register read wrong");

	a_rdata_hold: assert property (@(posedge mclk) disable iff (!rst_q)
		!reg_req.rd |=> $stable(rdata))
		else $error("read data moved without a read");

	a_irq_tick_sets: assert property (@(posedge mclk) disable iff (!rst_q)
		gen_tick |=> generator_irq_flag)
		else $error("request flag not set by tick");

	a_irq_clear_only: assert property (@(posedge mclk) disable iff (!rst_q)
		(irq_clr && !gen_tick) |=> !generator_irq_flag)
		else $error("request flag not cleared");

	a_irq_flag_hold: assert property (@(posedge mclk) disable iff (!rst_q)
		(!gen_tick && !irq_clr) |=> $stable(generator_irq_flag))
		else $error("request flag moved on its own");

	a_timer_start_edge: assert property (@(posedge mclk) disable iff (!rst_q)
		($rose(mode_q.gen_en) && mode_q.mode_sel) |-> tmr_start)
		else $error("timer start missing on enable rise");

	a_pwm_halt_high: assert property (@(posedge mclk) disable iff (!rst_q)
		!pwm_run |=> pwm_n)
		else $error("pwm output active while halted");

	a_square_halt_low: assert property (@(posedge mclk) disable iff (!rst_q)
		!tmr_run |=> !tmr_sq)
		else $error("square wave active while halted");

	a_reset_outputs_idle: assert property (@(posedge mclk) disable iff (!rst_q)
		$rose(rst_q)
			|-> !generator_irq_flag && rdata == 8'h00 && !pulse_output_pin)
		else $error("outputs not idle after reset");

	a_reset_regs_zero: assert property (@(posedge mclk) disable iff (!rst_q)
		$rose(rst_q) |-> modulo_high_q == TPG_MODULO_HIGH_RST && modulo_low_q == TPG_MODULO_LOW_RST)
		else $error("modulo registers not zero after reset");

	a_pin_oe_off: assert property (@(posedge mclk) disable iff (!rst_q)
		!mode_q.pin_oe |=> !pulse_output_pin_oe)
		else $error("pin driven while enable bit clear");

	a_square_on_pin: assert property (@(posedge mclk) disable iff (!rst_q)
		(mode_q.mode_sel && mode_q.out_sel) |=> pulse_output_pin == $past(tmr_sq))
		else $error("square wave not on pulse pin");

	a_pwm_on_pin: assert property (@(posedge mclk) disable iff (!rst_q)
		(!mode_q.mode_sel && mode_q.out_sel) |=> pulse_output_pin == $past(pwm_n))
		else $error("pwm waveform not on pulse pin");

endmodule : tpg_top
`default_nettype wire

// File: verilog/tpg_pkg.sv
// Constants, register map and carrier types of the timer/pulse generator.
// Assumes a single 125 MHz main clock shared by every user of the package.
package tpg_pkg;

	localparam logic [11:0] TPG_ADDR_MODE = 12'h0f90;
	localparam logic [11:0] TPG_ADDR_MODULO_HIGH = 12'h0f92;
	localparam logic [11:0] TPG_ADDR_MODULO_LOW = 12'h0f94;

	localparam logic [7:0] TPG_MODE_RST = 8'h00;
	localparam logic [7:0] TPG_MODULO_HIGH_RST = 8'h00;
	localparam logic [7:0] TPG_MODULO_LOW_RST = 8'h00;
	// Writable bits of the mode register; bits 6 and 2 read as zero
	localparam logic [7:0] TPG_MODE_WMASK = 8'hbb;
	// Low two bits of the low modulo register read back as zero
	localparam logic [7:0] TPG_MODULO_LOW_RMASK = 8'hfc;

	localparam int TPG_PSC_LSB = 2;
	localparam int TPG_PSC_MSB = 6;
	localparam int TPG_LATCH_W = 14;
	localparam int TPG_FINE_W = 4;
	localparam logic [9:0] TPG_BASE_LAST = 10'h03ff;
	localparam logic [14:0] TPG_SEC_LAST = 15'h7fff;

	typedef struct packed {
		logic pin_oe;
		logic rsv6;
		logic out_sel;
		logic stat_data;
		logic reload_en;
		logic rsv2;
		logic gen_en;
		logic mode_sel;
	} tpg_mode_type;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [7:0] wdata;
	} tpg_req_type;

	// Prescale mask from the one-hot low modulo bits 2..6
	function automatic logic [7:0] tpg_psc_mask(input logic [7:0] modulo_low);
		logic [7:0] m;
		m = 8'hff;
		case (modulo_low[TPG_PSC_MSB:TPG_PSC_LSB])
			5'b00001: m = 8'hff;
			5'b00010: m = 8'h7f;
			5'b00100: m = 8'h3f;
			5'b01000: m = 8'h1f;
			5'b10000: m = 8'h0f;
			default: m = 8'hff;
		endcase
		return m;
	endfunction : tpg_psc_mask

endpackage : tpg_pkg

// File: verilog/tpg_interval.sv
// Interval timer core: prescaler plus 8-bit modulo counter.
// Assumes run and start come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module tpg_interval
	import tpg_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic start,
	input wire logic [7:0] modulo_low,
	input wire logic [7:0] modulo_high,
	output logic tick,
	output logic sq
);

	logic [7:0] pre_q;
	logic [7:0] cnt_q;
	logic [7:0] mask;
	logic [7:0] half;

	assign mask = tpg_psc_mask(modulo_low);
	assign half = 8'(({1'b0, modulo_high} + 9'h001) >> 1);

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_q <= 8'h00;
			cnt_q <= 8'h00;
			tick <= 1'b0;
			sq <= 1'b0;
		end
		else if (!run || start)
		begin
			pre_q <= 8'h00;
			cnt_q <= 8'h00;
			tick <= 1'b0;
			sq <= 1'b0;
		end
		else
		begin
			tick <= 1'b0;
			sq <= (cnt_q < half);
			if (pre_q == mask)
			begin
				pre_q <= 8'h00;
				if (cnt_q == modulo_high)
				begin
					cnt_q <= 8'h00;
					tick <= 1'b1;
				end
				else
					cnt_q <= cnt_q + 8'h01;
			end
			else
				pre_q <= pre_q + 8'h01;
		end
	end

	a_timer_start_clear: assert property (@(posedge mclk) disable iff (!rst_n)
		start |=> (pre_q == 8'h00 && cnt_q == 8'h00 && !tick))
		else $error("timer did not restart from zero");

	a_timer_tick_match: assert property (@(posedge mclk) disable iff (!rst_n)
		(run && !start && pre_q == mask && cnt_q == modulo_high) |=> tick && cnt_q == 8'h00)
		else $error("timer interval tick missing at match");

endmodule : tpg_interval
`default_nettype wire

// File: verilog/tpg_pwm.sv
// PWM core: 2^10 basic period, 2^15 secondary period, 14-bit latch.
// Assumes reload_en and run come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module tpg_pwm
	import tpg_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic reload_en,
	input wire logic [7:0] modulo_high,
	input wire logic [7:0] modulo_low,
	output logic pwm_n,
	output logic tick
);

	logic [14:0] cnt_q;
	logic [TPG_LATCH_W-1:0] latch_q;
	logic [10:0] width;
	logic extra;

	function automatic logic [4:0] bitrev5(input logic [4:0] v);
		return {v[0], v[1], v[2], v[3], v[4]};
	endfunction : bitrev5

	// Fine bits spread one extra low cycle over the 32 basic periods
	assign extra = (bitrev5(cnt_q[14:10]) < {latch_q[TPG_FINE_W-1:0], 1'b0});
	assign width = {1'b0, latch_q[TPG_LATCH_W-1:TPG_FINE_W]} + {10'h000, extra};

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			latch_q <= '0;
		else if (reload_en && (!run || cnt_q[9:0] == TPG_BASE_LAST))
			latch_q <= {modulo_high, modulo_low[7:2]};
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= 15'h0000;
			pwm_n <= 1'b1;
			tick <= 1'b0;
		end
		else if (!run)
		begin
			cnt_q <= 15'h0000;
			pwm_n <= 1'b1;
			tick <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_q + 15'h0001;
			pwm_n <= !({1'b0, cnt_q[9:0]} < width);
			tick <= (cnt_q == TPG_SEC_LAST);
		end
	end

	a_latch_hold_off: assert property (@(posedge mclk) disable iff (!rst_n)
		!reload_en |=> $stable(latch_q))
		else $error("modulo latch changed with reload disabled");

	a_latch_boundary: assert property (@(posedge mclk) disable iff (!rst_n)
		$changed(latch_q) |-> cnt_q[9:0] == 10'h000)
		else $error("modulo latch changed inside a basic period");

	a_pwm_irq_period: assert property (@(posedge mclk) disable iff (!rst_n)
		tick |-> cnt_q == 15'h0000 && $past(run))
		else $error("pwm tick not at secondary period end");

	a_pwm_low_start: assert property (@(posedge mclk) disable iff (!rst_n)
		(run && cnt_q[9:0] == 10'h000 && width != 11'h000) |=> !pwm_n)
		else $error("pwm not low at start of basic period");

endmodule : tpg_pwm
`default_nettype wire

// File: bench/tpg_load.sv
// Load on the pulse pin: pull-up node plus a low-time accumulator.
// Assumes pin and enable are registered outputs on mclk.
`timescale 1ns/100ps
`default_nettype none
module tpg_load (
	input wire logic mclk,
	input wire logic pin,
	input wire logic pin_oe,
	output logic pin_level,
	output logic [15:0] low_cnt
);
	// Pull-up holds the node high while the pin floats
	assign pin_level = pin_oe ? pin : 1'b1;
	// One process owns the counter from time zero on
	initial
	begin
		low_cnt = 16'h0000;
		forever
		begin
			@(posedge mclk);
			if (pin_level == 1'b0)
				low_cnt <= low_cnt + 16'h0001;
		end
	end
endmodule : tpg_load
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the timer/pulse generator top.
// Assumes the load model pulls the pin node high while it floats.
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import tpg_pkg::*;
;
	typedef struct packed {
		logic [11:0] a;
		logic [7:0] w;
		logic [7:0] r;
		logic [7:0] p;
	} tpg_row_type;
	localparam int WD_CYC = 90000;
	logic mclk, nrst, reload_wr, reload_wdata, irq_clr, pin, pin_oe, flag, pin_level;
	tpg_req_type reg_req;
	logic [7:0] rdata, v;
	logic [15:0] low_cnt, lo;
	int err_total = 0;
	int n_tests = 0;
	int n;
	tpg_row_type rows [7] = '{'{12'h0f90, 8'h74, 8'h30, 8'h01}, '{12'h0f92, 8'ha5, 8'ha5, 8'h01},
		'{12'h0f94, 8'hff, 8'hfc, 8'h01}, '{12'h0f96, 8'h5a, 8'h00, 8'h01},
		'{12'h0f90, 8'h90, 8'h90, 8'h03}, '{12'h0f90, 8'h80, 8'h80, 8'h02},
		'{12'h0f90, 8'hb0, 8'hb0, 8'h03}};

	tpg_top DUT (.mclk(mclk), .nrst(nrst), .reg_req(reg_req), .reload_wr(reload_wr),
		.reload_wdata(reload_wdata), .irq_clr(irq_clr), .rdata(rdata), .pulse_output_pin(pin),
		.pulse_output_pin_oe(pin_oe), .generator_irq_flag(flag));
	tpg_load LOAD (.mclk(mclk), .pin(pin), .pin_oe(pin_oe), .pin_level(pin_level),
		.low_cnt(low_cnt));

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out

	task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_reg

	task automatic chk_cnt(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] %s expected %0d seen %0d", nm, e, g);
		end
	endtask : chk_cnt

	task automatic reset_dut();
		nrst <= 1'b0;
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		repeat (3) @(posedge mclk);
	endtask : reset_dut

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk) reg_req <= '{1'b1, 1'b0, a, d};
		@(posedge mclk) reg_req <= '{1'b0, 1'b0, 12'h0000, 8'h00};
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge mclk) reg_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge mclk) reg_req <= '{1'b0, 1'b0, 12'h0000, 8'h00};
		#1;
		d = rdata;
	endtask : rd

	task automatic rl(input logic b);
		@(posedge mclk)
		begin
			reload_wr <= 1'b1;
			reload_wdata <= b;
		end
		@(posedge mclk) reload_wr <= 1'b0;
	endtask : rl

	task automatic pulse_clr();
		@(posedge mclk) irq_clr <= 1'b1;
		@(posedge mclk) irq_clr <= 1'b0;
	endtask : pulse_clr

	task automatic to_flag(inout int c);
		do
		begin
			@(posedge mclk);
			c++;
			#1;
		end while (flag !== 1'b1 && c < 70000);
		if (flag !== 1'b1)
		begin
			err_total++;
			$display("[ERR] flag_wait expected 1 seen %b", flag);
		end
	endtask : to_flag

	// Edges between two flag settings and pin low time over that span
	task automatic span(output int c, output logic [15:0] l);
		logic [15:0] s;
		c = 0;
		pulse_clr();
		to_flag(c);
		s = low_cnt;
		c = 2;
		pulse_clr();
		to_flag(c);
		l = low_cnt - s;
	endtask : span

	task automatic win(input int c, output logic [15:0] l);
		logic [15:0] s;
		#1;
		s = low_cnt;
		repeat (c) @(posedge mclk);
		#1;
		l = low_cnt - s;
	endtask : win

	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	initial
	begin
		repeat (WD_CYC) @(posedge mclk);
		err_total++;
		close_out();
	end

	initial
	begin
		nrst = 1'b0;
		reg_req = '0;
		reload_wr = 1'b0;
		reload_wdata = 1'b0;
		irq_clr = 1'b0;
		reset_dut();
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, v);
			chk_reg("reg_read", rows[i].r, v);
			chk_reg("pin_state", rows[i].p, {6'h00, pin_oe, pin_level});
		end
		$display("test registers done");
		rl(1'b1);
		rd(TPG_ADDR_MODE, v);
		chk_reg("reload_set", 8'hb8, v);
		rl(1'b0);
		rd(TPG_ADDR_MODE, v);
		chk_reg("reload_clr", 8'hb0, v);
		$display("test reload done");
		wr(TPG_ADDR_MODULO_HIGH, 8'h01);
		for (int i = 0; i < 5; i++)
		begin
			wr(TPG_ADDR_MODULO_LOW, 8'h04 << i);
			if (i == 0)
				wr(TPG_ADDR_MODE, 8'hab);
			span(n, lo);
			chk_cnt("interval", 16'(512 >> i), 16'(n));
			chk_cnt("square_low", 16'(256 >> i), lo);
		end
		// Clear held high: flag shows only the ticks, one per 32 clocks
		@(posedge mclk) irq_clr <= 1'b1;
		repeat (2) @(posedge mclk);
		n = 0;
		repeat (320)
		begin
			@(posedge mclk);
			#1;
			if (flag === 1'b1)
				n++;
		end
		@(posedge mclk) irq_clr <= 1'b0;
		chk_cnt("set_wins", 16'd10, 16'(n));
		wr(TPG_ADDR_MODE, 8'h00);
		pulse_clr();
		win(600, lo);
		chk_reg("flag_stopped", 8'h00, {7'h00, flag});
		$display("test timer done");
		wr(TPG_ADDR_MODULO_HIGH, 8'h40);
		wr(TPG_ADDR_MODULO_LOW, 8'h14);
		wr(TPG_ADDR_MODE, 8'haa);
		span(n, lo);
		chk_cnt("pwm_flag", 16'h8000, 16'(n));
		chk_cnt("pwm_low", 16'd8202, lo);
		rl(1'b0);
		wr(TPG_ADDR_MODULO_HIGH, 8'h10);
		wr(TPG_ADDR_MODULO_LOW, 8'h00);
		repeat (2048) @(posedge mclk);
		win(1024, lo);
		chk_cnt("latch_held", 16'h0001, 16'(lo >= 256 && lo <= 257));
		rl(1'b1);
		repeat (2048) @(posedge mclk);
		win(1024, lo);
		chk_cnt("latch_new", 16'd64, lo);
		wr(TPG_ADDR_MODE, 8'ha8);
		// Pin trails the halt by two clocks
		repeat (2) @(posedge mclk);
		win(200, lo);
		chk_cnt("pwm_halt", 16'h0000, lo);
		$display("test pwm done");
		@(posedge mclk);
		reset_dut();
		rd(TPG_ADDR_MODE, v);
		chk_reg("mode_rst", TPG_MODE_RST, v);
		rd(TPG_ADDR_MODULO_HIGH, v);
		chk_reg("modulo_high_rst", TPG_MODULO_HIGH_RST, v);
		chk_reg("pins_rst", 8'h01, {6'h00, pin_oe, pin_level});
		$display("test reset done");
		close_out();
	end
endmodule : tb_top
`default_nettype wire
